// File: cbc_pkg.sv
// Constants, types and helpers of the clock buffer control block
package cbc_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h6E;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ENABLES = 8'h01;
	localparam logic [7:0] CTRL_RESET = 8'h07;
	localparam logic [7:0] CTRL_MASK = 8'hC7;
	localparam logic [7:0] ENABLES_RESET = 8'h66;
	localparam logic [7:0] ENABLES_MASK = 8'h66;
	localparam logic [7:0] READ_COUNT = 8'h02;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	localparam int MODE_BIT = 0;
	localparam int PLL_BIT = 1;
	localparam int BW_BIT = 2;
	localparam int STOP_TRI_BIT = 6;
	localparam int PD_TRI_BIT = 7;
	localparam int PAIR0_BIT = 1;
	localparam int PAIR1_BIT = 2;
	localparam int PAIR2_BIT = 5;
	localparam int PAIR3_BIT = 6;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_OFFS,
		ST_CNT,
		ST_WDATA,
		ST_ACK_SETUP,
		ST_ACK_HOLD,
		ST_TX,
		ST_HACK,
		ST_IGNORE
	} cbc_state_t;

	// Pair enables gathered from the enable byte, pair 0 in bit 0
	function automatic logic [3:0] cbc_pair_enables(input logic [7:0] en);
		cbc_pair_enables = {en[PAIR3_BIT], en[PAIR2_BIT], en[PAIR1_BIT],
			en[PAIR0_BIT]};
	endfunction

	// Pin level after the optional polarity inversion
	function automatic logic cbc_pin(input logic lvl, input logic inv);
		cbc_pin = lvl ^ inv;
	endfunction
endpackage

// File: cbc_reg_if.sv
// Register access and control byte carrier between serial engine and bank
interface cbc_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] ctrl;
	logic [7:0] enables;
	modport engine (
		output wr_en, wr_addr, wr_data, rd_addr,
		input rd_data, ctrl, enables
	);
	modport bank (
		input wr_en, wr_addr, wr_data, rd_addr,
		output rd_data, ctrl, enables
	);
endinterface

// File: cbc_line_mon.sv
// Serial line sampler with edge, start and stop detection
module cbc_line_mon
	import cbc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Raw lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Events
	output logic sda_level,
	output logic scl_rise,
	output logic scl_fall,
	output logic bus_start,
	output logic bus_stop
);
	logic scl_reg;
	logic sda_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_reg <= scl_in;
			sda_reg <= sda_in;
			scl_prev_reg <= scl_reg;
			sda_prev_reg <= sda_reg;
		end
	end

	assign sda_level = sda_reg;
	assign scl_rise = scl_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_reg & scl_prev_reg;
	assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
	assign bus_stop = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
endmodule

// File: cbc_regs.sv
// Control byte bank with masked writes and registered read data
module cbc_regs
	import cbc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Access port
	cbc_reg_if.bank rif
);
	logic [7:0] ctrl_reg;
	logic [7:0] enables_reg;
	logic [7:0] rd_data_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
			enables_reg <= ENABLES_RESET;
		end else if (rif.wr_en) begin
			if (rif.wr_addr == REG_CTRL) begin
				ctrl_reg <= rif.wr_data & CTRL_MASK;
			end
			if (rif.wr_addr == REG_ENABLES) begin
				enables_reg <= rif.wr_data & ENABLES_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data_reg <= UNMAPPED_DATA;
		end else begin
			case (rif.rd_addr)
				REG_CTRL: rd_data_reg <= ctrl_reg;
				REG_ENABLES: rd_data_reg <= enables_reg;
				default: rd_data_reg <= UNMAPPED_DATA;
			endcase
		end
	end

	assign rif.rd_data = rd_data_reg;
	assign rif.ctrl = ctrl_reg;
	assign rif.enables = enables_reg;

	property p_reserved_zero;
		@(posedge sys_clk) disable iff (rst)
		((ctrl_reg & ~CTRL_MASK) == 8'h00) &&
			((enables_reg & ~ENABLES_MASK) == 8'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bit set");

	property p_write_lands;
		@(posedge sys_clk) disable iff (rst)
		(rif.wr_en && rif.wr_addr == REG_ENABLES) |=>
			enables_reg == ($past(rif.wr_data) & ENABLES_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("enable byte write lost");
endmodule

// File: cbc_top.sv
// Serial target engine and output control of the four-pair clock buffer
module cbc_top
	import cbc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Control pins
	input wire logic pair0_enable,
	input wire logic pair3_enable,
	input wire logic control_polarity_invert,
	input wire logic clock_stop_n,
	input wire logic power_down_n,
	input wire logic pll_select,
	input wire logic pll_bandwidth_select,
	// Output control
	output logic [3:0] out_run,
	output logic [3:0] out_tristate,
	output logic out_divide_by_two,
	output logic pll_active,
	output logic pll_low_bandwidth
);
	cbc_reg_if rif ();

	cbc_state_t state_reg;
	cbc_state_t ret_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] offset_reg;
	logic [7:0] remain_reg;
	logic sda_oe_n_reg;
	logic wr_en_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic [3:0] out_run_reg;
	logic [3:0] out_tristate_reg;
	logic divide_reg;
	logic pll_reg;
	logic low_bw_reg;

	logic sda_level;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] byte_in;
	logic byte_done;
	logic stopped;
	logic powered_down;
	logic [3:0] pin_enables;

	cbc_line_mon u_mon (
		.sys_clk(sys_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_level(sda_level),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.bus_start(bus_start),
		.bus_stop(bus_stop)
	);

	cbc_regs u_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.rif(rif)
	);

	assign byte_in = {shift_reg[6:0], sda_level};
	assign byte_done = scl_rise && (bit_cnt_reg == LAST_BIT);

	// Serial engine
	always_ff @(posedge sys_clk) begin
		wr_en_reg <= 1'b0;
		if (rst) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			offset_reg <= 8'h00;
			remain_reg <= 8'h00;
			sda_oe_n_reg <= 1'b1;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else if (bus_start) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= 3'h0;
			sda_oe_n_reg <= 1'b1;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
			sda_oe_n_reg <= 1'b1;
		end else begin
			case (state_reg)
				ST_ADDR, ST_OFFS, ST_CNT, ST_WDATA: begin
					if (scl_rise) begin
						shift_reg <= byte_in;
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
					if (byte_done) begin
						state_reg <= ST_ACK_SETUP;
						case (state_reg)
							ST_ADDR: begin
								if (byte_in[7:1] != TARGET_ADDR) begin
									state_reg <= ST_IGNORE;
								end else if (byte_in[0]) begin
									ret_reg <= ST_TX;
									shift_reg <= READ_COUNT;
								end else begin
									ret_reg <= ST_OFFS;
								end
							end
							ST_OFFS: begin
								offset_reg <= byte_in;
								ret_reg <= ST_CNT;
							end
							ST_CNT: begin
								remain_reg <= byte_in;
								// Zero count leaves nothing to accept
								ret_reg <= (byte_in == 8'h00) ? ST_IGNORE :
									ST_WDATA;
							end
							default: begin
								if (remain_reg == 8'h00) begin
									state_reg <= ST_IGNORE;
								end else begin
									wr_en_reg <= 1'b1;
									wr_addr_reg <= offset_reg;
									wr_data_reg <= byte_in;
									offset_reg <= offset_reg + 8'h01;
									remain_reg <= remain_reg - 8'h01;
									ret_reg <= ST_WDATA;
								end
							end
						endcase
					end
				end
				ST_ACK_SETUP: begin
					if (scl_fall) begin
						sda_oe_n_reg <= 1'b0;
						bit_cnt_reg <= 3'h0;
						state_reg <= ST_ACK_HOLD;
					end
				end
				ST_ACK_HOLD: begin
					if (scl_fall) begin
						state_reg <= ret_reg;
						sda_oe_n_reg <= (ret_reg == ST_TX) ? shift_reg[7] : 1'b1;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						sda_oe_n_reg <= shift_reg[7];
					end
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == LAST_BIT) begin
							state_reg <= ST_HACK;
						end
					end
				end
				ST_HACK: begin
					if (scl_fall) begin
						sda_oe_n_reg <= 1'b1;
					end
					if (scl_rise) begin
						bit_cnt_reg <= 3'h0;
						if (!sda_level) begin
							shift_reg <= rif.rd_data;
							offset_reg <= offset_reg + 8'h01;
							state_reg <= ST_TX;
						end else begin
							state_reg <= ST_IGNORE;
						end
					end
				end
				ST_IDLE, ST_IGNORE: begin
					sda_oe_n_reg <= 1'b1;
				end
				default: begin
					state_reg <= ST_IDLE;
					sda_oe_n_reg <= 1'b1;
				end
			endcase
		end
	end

	assign rif.wr_en = wr_en_reg;
	assign rif.wr_addr = wr_addr_reg;
	assign rif.wr_data = wr_data_reg;
	assign rif.rd_addr = offset_reg;
	assign sda_out = 1'b0;
	assign sda_oe_n = sda_oe_n_reg;

	// Pin conditioning
	assign stopped = ~cbc_pin(clock_stop_n, control_polarity_invert);
	assign powered_down = ~cbc_pin(power_down_n, control_polarity_invert);
	assign pin_enables = {cbc_pin(pair3_enable, control_polarity_invert),
		2'b11, cbc_pin(pair0_enable, control_polarity_invert)};

	// Output control
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_run_reg <= 4'h0;
			out_tristate_reg <= 4'h0;
		end else begin
			if (stopped || powered_down) begin
				out_run_reg <= 4'h0;
			end else begin
				out_run_reg <= cbc_pair_enables(rif.enables) & pin_enables;
			end
			out_tristate_reg <= {4{(stopped && rif.ctrl[STOP_TRI_BIT]) ||
				(powered_down && rif.ctrl[PD_TRI_BIT])}};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divide_reg <= 1'b0;
			pll_reg <= 1'b1;
			low_bw_reg <= 1'b1;
		end else begin
			divide_reg <= ~rif.ctrl[MODE_BIT];
			pll_reg <= rif.ctrl[PLL_BIT] & pll_select;
			low_bw_reg <= rif.ctrl[BW_BIT] & pll_bandwidth_select;
		end
	end

	assign out_run = out_run_reg;
	assign out_tristate = out_tristate_reg;
	assign out_divide_by_two = divide_reg;
	assign pll_active = pll_reg;
	assign pll_low_bandwidth = low_bw_reg;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	property p_addr_ignore;
		(state_reg == ST_ADDR && byte_done && !bus_start && !bus_stop &&
			byte_in[7:1] != TARGET_ADDR) |=>
			(state_reg == ST_IGNORE && sda_oe_n);
	endproperty
	a_addr_ignore: assert property (p_addr_ignore)
		else $error("foreign address not ignored");

	property p_ack_drive;
		(state_reg == ST_ACK_SETUP && scl_fall && !bus_start && !bus_stop)
			|=> !sda_oe_n && state_reg == ST_ACK_HOLD;
	endproperty
	a_ack_drive: assert property (p_ack_drive)
		else $error("acknowledge not driven");

	property p_target_only;
		(state_reg == ST_IDLE || state_reg == ST_IGNORE) |=> sda_oe_n;
	endproperty
	a_target_only: assert property (p_target_only)
		else $error("line driven while not addressed");

	property p_offset_step;
		wr_en_reg |-> offset_reg == wr_addr_reg + 8'h01;
	endproperty
	a_offset_step: assert property (p_offset_step)
		else $error("offset did not advance");

	property p_halt;
		(stopped || powered_down) |=> out_run == 4'h0;
	endproperty
	a_halt: assert property (p_halt)
		else $error("outputs running while halted");

	property p_inverted_pins;
		(control_polarity_invert && !clock_stop_n && !power_down_n &&
			!pair0_enable && rif.enables[PAIR0_BIT]) |=> out_run[0] == 1'b1;
	endproperty
	a_inverted_pins: assert property (p_inverted_pins)
		else $error("inversion not applied");

	property p_pair0_pin;
		(!control_polarity_invert && clock_stop_n && power_down_n &&
			rif.enables[PAIR0_BIT]) |=> out_run[0] == $past(pair0_enable);
	endproperty
	a_pair0_pin: assert property (p_pair0_pin)
		else $error("pair 0 enable pin ignored");

	property p_reg_enable;
		!rif.enables[PAIR2_BIT] |=> !out_run[2];
	endproperty
	a_reg_enable: assert property (p_reg_enable)
		else $error("pair 2 runs while disabled");

	property p_mode;
		##1 out_divide_by_two == !$past(rif.ctrl[MODE_BIT]);
	endproperty
	a_mode: assert property (p_mode)
		else $error("divide mode mismatch");

	property p_fanout;
		(!rif.ctrl[PLL_BIT] || !pll_select) |=> !pll_active;
	endproperty
	a_fanout: assert property (p_fanout)
		else $error("PLL active in fanout");

	property p_bandwidth;
		!rif.ctrl[BW_BIT] |=> !pll_low_bandwidth;
	endproperty
	a_bandwidth: assert property (p_bandwidth)
		else $error("low bandwidth while high chosen");

	property p_stop_tri;
		(stopped && rif.ctrl[STOP_TRI_BIT]) |=> out_tristate == 4'hF;
	endproperty
	a_stop_tri: assert property (p_stop_tri)
		else $error("stopped outputs not tristated");

	property p_pd_tri;
		(powered_down && !stopped && !rif.ctrl[PD_TRI_BIT]) |=>
			out_tristate == 4'h0;
	endproperty
	a_pd_tri: assert property (p_pd_tri)
		else $error("powered down outputs not driven");
endmodule

// File: cbc_host.sv
// Two-wire host model driving the serial clock and data lines
module cbc_host (
	// Clock
	input wire logic sys_clk,
	// Wire levels
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sda_drv = 1'b1;
	// Both lines released high outside frames
	initial scl = 1'b1;
	// Open drain data with pull-up
	assign sda = sda_drv & sda_oe_n;

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Data set in low phase, sampled late in high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		cyc(6);
		scl <= 1'b1;
		cyc(5);
		r = sda;
		cyc(1);
		scl <= 1'b0;
		cyc(2);
	endtask

	task automatic start();
		sda_drv <= 1'b1;
		cyc(6);
		scl <= 1'b1;
		cyc(6);
		sda_drv <= 1'b0;
		cyc(6);
		scl <= 1'b0;
		cyc(2);
	endtask

	task automatic stop();
		sda_drv <= 1'b0;
		cyc(6);
		scl <= 1'b1;
		cyc(6);
		sda_drv <= 1'b1;
		cyc(6);
	endtask

	// Byte out MSB first, then acknowledge sampled
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic recv(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// File: smbus_clock_output_control_test.sv
// Self-checking bench of the clock buffer control block
module smbus_clock_output_control_test
	import cbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic scl_in, sda_in, sda_out, sda_oe_n;
	logic pair0_enable = 1'b1;
	logic pair3_enable = 1'b1;
	logic control_polarity_invert = 1'b0;
	logic clock_stop_n = 1'b1;
	logic power_down_n = 1'b1;
	logic pll_select = 1'b1;
	logic pll_bandwidth_select = 1'b1;
	logic [3:0] out_run, out_tristate;
	logic out_divide_by_two, pll_active, pll_low_bandwidth;
	logic [7:0] ctrl_exp = 8'h07;
	logic [7:0] en_exp = 8'h66;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;

	always #4 sys_clk = ~sys_clk;

	cbc_top DUT (.sys_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
		.pair0_enable, .pair3_enable, .control_polarity_invert,
		.clock_stop_n, .power_down_n, .pll_select, .pll_bandwidth_select,
		.out_run, .out_tristate, .out_divide_by_two, .pll_active,
		.pll_low_bandwidth);
	cbc_host host (.sys_clk, .sda_oe_n, .scl(scl_in), .sda(sda_in));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Block write; count is never zero
	task automatic wr(input logic [7:0] offs, cnt, d0, d1, input int nd);
		logic a;
		host.start();
		host.send({TARGET_ADDR, 1'b0}, a);
		check({7'h0, a}, 8'h01);
		host.send(offs, a);
		check({7'h0, a}, 8'h01);
		host.send(cnt, a);
		check({7'h0, a}, 8'h01);
		for (int i = 0; i < nd; i++) begin
			host.send(i == 0 ? d0 : d1, a);
			check({7'h0, a}, i < cnt ? 8'h01 : 8'h00);
		end
		host.stop();
	endtask

	// Offset set by write, then repeated start and block read
	task automatic rd(input logic [7:0] offs, e0, e1);
		logic a;
		logic [7:0] b;
		host.start();
		host.send({TARGET_ADDR, 1'b0}, a);
		host.send(offs, a);
		host.start();
		host.send({TARGET_ADDR, 1'b1}, a);
		check({7'h0, a}, 8'h01);
		host.recv(1'b0, b);
		check(b, READ_COUNT);
		host.recv(1'b0, b);
		check(b, e0);
		host.recv(1'b1, b);
		check(b, e1);
		host.stop();
	endtask

	task automatic bad_addr();
		logic a;
		host.start();
		host.send({7'h6F, 1'b0}, a);
		check({7'h0, a}, 8'h00);
		check({7'h0, sda_out}, 8'h00);
		host.stop();
	endtask

	// Every pin combination against the current register contents
	task automatic pins();
		logic inv, s, p;
		logic [3:0] run;
		logic [7:0] e_run, e_tri, e_pll, e_bw;
		for (int i = 0; i < 128; i++) begin
			{control_polarity_invert, pair0_enable, pair3_enable,
				clock_stop_n, power_down_n, pll_select,
				pll_bandwidth_select} <= i[6:0];
			repeat (3) @(posedge sys_clk);
			inv = control_polarity_invert;
			s = !(clock_stop_n ^ inv);
			p = !(power_down_n ^ inv);
			run = {(pair3_enable ^ inv) & en_exp[6], en_exp[5], en_exp[2],
				(pair0_enable ^ inv) & en_exp[1]};
			e_run = (s | p) ? 8'h00 : {4'h0, run};
			e_tri = ((s & ctrl_exp[6]) | (p & ctrl_exp[7])) ? 8'h0F : 8'h00;
			e_pll = {7'h0, ctrl_exp[1] & pll_select};
			e_bw = {7'h0, ctrl_exp[2] & pll_bandwidth_select};
			check({4'h0, out_run}, e_run);
			check({4'h0, out_tristate}, e_tri);
			check({7'h0, out_divide_by_two}, {7'h0, !ctrl_exp[0]});
			check({7'h0, pll_active}, e_pll);
			check({7'h0, pll_low_bandwidth}, e_bw);
		end
		{control_polarity_invert, pair0_enable, pair3_enable, clock_stop_n,
			power_down_n, pll_select, pll_bandwidth_select} <= 7'h3F;
		repeat (3) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		pins();
		rd(REG_CTRL, 8'h07, 8'h66);
		bad_addr();
		wr(REG_CTRL, 8'h02, 8'hFA, 8'hDB, 2);
		ctrl_exp = 8'hC2;
		en_exp = 8'h42;
		rd(REG_ENABLES, 8'h42, 8'h00);
		rd(REG_CTRL, 8'hC2, 8'h42);
		pins();
		wr(REG_CTRL, 8'h01, 8'h07, 8'h00, 2);
		ctrl_exp = 8'h07;
		rd(REG_CTRL, 8'h07, 8'h42);
		end_sim();
	end
endmodule
